// ==== rtl/acs_sequencer.sv ====
// Conversion sequencer of a 10-bit successive approximation converter.
// Assumes an analog macro delivering an 11-bit approximation (one guard
// bit) and two free-running clock pins, all asynchronous to clk.
`timescale 1ns/100ps
`include "acs_map.svh"

module acs_sequencer
    import acs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic stop_req,
    input wire logic alt_clk_pin,
    input wire logic async_osc_pin,
    input wire logic [10:0] approx_in,
    output logic [4:0] channel_sel,
    output logic sample_en,
    output logic analog_power_en,
    output logic irq_req
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    acs_sc_t sc_r;
    acs_cfg_t cfg_r;
    logic flag_r;
    logic irq_r;
    logic hi_pend_r;
    logic [1:0] res_hi_r;
    logic [7:0] res_lo_r;
    logic [7:0] rdata_r;
    acs_state_t state_r;
    logic [5:0] cnt_r;
    logic [8:0] wake_r;
    logic [10:0] smp_r;

    logic wr_sc;
    logic wr_clk;
    logic rd_hi;
    logic rd_lo;
    logic stop_abort;
    logic abort;
    logic xfer;
    logic blocked;
    logic ck_tick;

    // Register strobes
    assign wr_sc = reg_wr && (reg_addr == `ACS_OFF_SC);
    assign wr_clk = reg_wr && (reg_addr == `ACS_OFF_CLKCFG);
    assign rd_hi = reg_rd && (reg_addr == `ACS_OFF_RES_HI);
    assign rd_lo = reg_rd && (reg_addr == `ACS_OFF_RES_LO);
    assign stop_abort = stop_req && !cfg_r.async_en;
    assign abort = wr_sc || wr_clk || stop_abort;
    assign xfer = (state_r == ACS_XFER);
    assign blocked = cfg_r.mode10 && hi_pend_r;

    // Control registers written by software
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sc_r <= acs_sc_t'(7'(`ACS_SC_RESET));
            cfg_r <= acs_cfg_t'(6'(`ACS_CLKCFG_RESET));
        end else begin
            if (wr_sc) begin
                sc_r <= acs_sc_t'(reg_wdata[6:0]);
            end
            if (wr_clk) begin
                cfg_r <= acs_cfg_t'(reg_wdata[5:0]);
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `ACS_OFF_SC) begin
                rdata_r <= {flag_r, sc_r};
            end else if (reg_addr == `ACS_OFF_RES_HI) begin
                rdata_r <= {6'h00, res_hi_r};
            end else if (reg_addr == `ACS_OFF_RES_LO) begin
                rdata_r <= res_lo_r;
            end else if (reg_addr == `ACS_OFF_CLKCFG) begin
                rdata_r <= {2'h0, cfg_r};
            end else begin
                rdata_r <= 8'h00;
            end
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign reg_rdata = rdata_r;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    localparam int SW = 13;
    logic [SW-1:0] pin_vec;
    logic [SW-1:0] s1_r;
    logic [SW-1:0] s2_r;
    logic [SW-1:0] s3_r;
    logic [SW-1:0] filt_r;
    logic alt_prev_r;
    logic osc_prev_r;

    assign pin_vec = {alt_clk_pin, async_osc_pin, approx_in};

    // Three flops per pin; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                    filt_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= pin_vec[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) begin
                        filt_r[gi] <= s3_r[gi];
                    end
                end
            end
        end
    endgenerate

    // Edge history of the two clock pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alt_prev_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end else begin
            alt_prev_r <= filt_r[12];
            osc_prev_r <= filt_r[11];
        end
    end

    // ****************************************************************
    // Converter clock select and divide
    // ****************************************************************
    logic src_tick;
    logic [2:0] div_r;
    logic [2:0] div_mask;

    // Mask of divider bits that must be all ones for one tick
    function automatic logic [2:0] div_mask_f(input logic [1:0] d);
        logic [2:0] m;
        m = 3'h0;
        if (d == 2'h1) begin
            m = 3'h1;
        end else if (d == 2'h2) begin
            m = 3'h3;
        end else if (d == 2'h3) begin
            m = 3'h7;
        end
        return m;
    endfunction

    always_comb begin
        if (cfg_r.async_en) begin
            src_tick = filt_r[11] && !osc_prev_r;
        end else if (cfg_r.bus_sel) begin
            src_tick = 1'b1;
        end else begin
            src_tick = filt_r[12] && !alt_prev_r;
        end
    end

    assign div_mask = div_mask_f(cfg_r.div);
    assign ck_tick = src_tick && ((div_r & div_mask) == div_mask);

    always_ff @(posedge clk) begin
        if (!rst_n || abort || state_r == ACS_IDLE) begin
            div_r <= 3'h0;
        end else if (src_tick) begin
            div_r <= div_r + 3'h1;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    logic [5:0] smp_len;
    logic [5:0] cnv_len;
    assign smp_len = cfg_r.long_smp ? `ACS_SMP_LONG : `ACS_SMP_SHORT;
    assign cnv_len = cfg_r.mode10 ? `ACS_CNV_10 : `ACS_CNV_8;

    // State and cycle counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ACS_IDLE;
            cnt_r <= 6'h00;
            wake_r <= 9'h000;
        end else if (abort) begin
            cnt_r <= 6'h00;
            wake_r <= 9'h000;
            if (wr_sc && reg_wdata[4:0] != `ACS_CHAN_OFF && !stop_abort) begin
                state_r <= ACS_SYNC;
            end else begin
                state_r <= ACS_IDLE;
            end
        end else begin
            case (state_r)
                ACS_IDLE: begin
                    cnt_r <= 6'h00;
                end
                ACS_SYNC: begin
                    if (cnt_r == `ACS_SYNC_BUS - 6'h01) begin
                        cnt_r <= 6'h00;
                        state_r <= cfg_r.async_en ? ACS_WAKE : ACS_START;
                    end else begin
                        cnt_r <= cnt_r + 6'h01;
                    end
                end
                ACS_WAKE: begin
                    wake_r <= wake_r + 9'h001;
                    if (ck_tick || wake_r == 9'(`ACS_STARTUP_CYC - 1)) begin
                        wake_r <= 9'h000;
                        state_r <= ACS_START;
                    end
                end
                ACS_START: begin
                    if (ck_tick) begin
                        if (cnt_r == `ACS_START_CK - 6'h01) begin
                            cnt_r <= 6'h00;
                            state_r <= ACS_SAMPLE;
                        end else begin
                            cnt_r <= cnt_r + 6'h01;
                        end
                    end
                end
                ACS_SAMPLE: begin
                    if (ck_tick) begin
                        if (cnt_r == smp_len - 6'h01) begin
                            cnt_r <= 6'h00;
                            state_r <= ACS_CONVERT;
                        end else begin
                            cnt_r <= cnt_r + 6'h01;
                        end
                    end
                end
                ACS_CONVERT: begin
                    if (ck_tick) begin
                        if (cnt_r == cnv_len - 6'h01) begin
                            cnt_r <= 6'h00;
                            state_r <= ACS_XFER;
                        end else begin
                            cnt_r <= cnt_r + 6'h01;
                        end
                    end
                end
                ACS_XFER: begin
                    if (blocked) begin
                        state_r <= ACS_SYNC;
                    end else if (sc_r.cont) begin
                        state_r <= ACS_SAMPLE;
                    end else begin
                        state_r <= ACS_IDLE;
                    end
                end
                default: begin
                    state_r <= ACS_IDLE;
                end
            endcase
        end
    end

    // Approximation captured as the sample window closes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            smp_r <= 11'h000;
        end else if (state_r == ACS_SAMPLE && ck_tick &&
                     cnt_r == smp_len - 6'h01) begin
            smp_r <= filt_r[10:0];
        end
    end

    // ****************************************************************
    // Rounding and result transfer
    // ****************************************************************
    logic [11:0] sum10;
    logic [11:0] sum8;
    logic [9:0] code10;
    logic [7:0] code8;
    assign sum10 = {1'b0, smp_r} + 12'h001;
    assign sum8 = {1'b0, smp_r} + 12'h004;
    assign code10 = sum10[11] ? 10'h3FF : sum10[10:1];
    assign code8 = sum8[11] ? 8'hFF : sum8[10:3];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            res_hi_r <= 2'h0;
            res_lo_r <= 8'h00;
        end else if (xfer && !abort && !blocked) begin
            if (cfg_r.mode10) begin
                res_hi_r <= code10[9:8];
                res_lo_r <= code10[7:0];
            end else begin
                res_hi_r <= 2'h0;
                res_lo_r <= code8;
            end
        end
    end

    // in 10-bit mode a high read opens, a low read closes the pair
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hi_pend_r <= 1'b0;
        end else if (rd_lo) begin
            hi_pend_r <= 1'b0;
        end else if (rd_hi && cfg_r.mode10) begin
            hi_pend_r <= 1'b1;
        end
    end

    // flag set on transfer; set wins over a low-byte read clear, while an SC write aborts the transfer and clears
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (xfer && !abort && !blocked) begin
            flag_r <= 1'b1;
            irq_r <= sc_r.ien;
        end else if (wr_sc || rd_lo) begin
            flag_r <= 1'b0;
            irq_r <= 1'b0;
        end
    end

    assign irq_req = irq_r;
    assign channel_sel = sc_r.chan;
    assign sample_en = (state_r == ACS_SAMPLE);
    // clocks and references off while inactive
    assign analog_power_en = (state_r != ACS_IDLE);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_good_xfer;
        xfer && !abort && !blocked;
    endsequence
    sequence s_bad_xfer;
        xfer && !abort && blocked;
    endsequence

    AST_FLAG_ON_XFER: assert property (@(posedge clk) disable iff (!rst_n)
        s_good_xfer |=> flag_r)
        else $error("flag not set after transfer");
    AST_IRQ_ENABLE: assert property (@(posedge clk) disable iff (!rst_n)
        s_good_xfer |=> (irq_r == $past(sc_r.ien)))
        else $error("irq does not follow enable at completion");
    AST_BLOCK_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
        s_bad_xfer |=> $stable(res_lo_r) && $stable(res_hi_r) &&
        flag_r == ($past(flag_r) && !$past(rd_lo)))
        else $error("blocked transfer changed result or flag");
    AST_BLOCK_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
        s_bad_xfer |=> state_r == ACS_SYNC)
        else $error("blocked transfer did not restart");
    AST_WRITE_ABORT: assert property (@(posedge clk) disable iff (!rst_n)
        wr_sc && reg_wdata[4:0] == 5'h1F |=> state_r == ACS_IDLE)
        else $error("channel off write did not idle");
    AST_CLK_ABORT: assert property (@(posedge clk) disable iff (!rst_n)
        wr_clk |=> state_r == ACS_IDLE && !analog_power_en)
        else $error("clock write did not abort");
    AST_STOP_ABORT: assert property (@(posedge clk) disable iff (!rst_n)
        stop_abort && !wr_sc |=> state_r == ACS_IDLE)
        else $error("stop did not abort");
    AST_ABORT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        abort |=> $stable(res_lo_r) && $stable(res_hi_r))
        else $error("abort altered results");
    AST_SYNC_LEN: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state_r == ACS_SYNC) && !abort ##1 (!abort) [*2] |=>
        state_r != ACS_SYNC)
        else $error("sync phase not three bus clocks");
    AST_RES8_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        (s_good_xfer and !cfg_r.mode10) |=> res_hi_r == 2'h0)
        else $error("8-bit result touched high byte");

endmodule // acs_sequencer

// ==== rtl/acs_map.svh ====
// Register offsets, field positions, reset values and timing counts
// of the conversion sequencer. Included by the sequencer file.
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
// Register offsets on the 3-bit register port
`define ACS_OFF_SC 3'h0
`define ACS_OFF_RES_HI 3'h1
`define ACS_OFF_RES_LO 3'h2
`define ACS_OFF_CLKCFG 3'h3
// Status and control fields
`define ACS_SC_FLAG_BIT 7
`define ACS_SC_IEN_BIT 6
`define ACS_SC_CONT_BIT 5
`define ACS_CHAN_OFF 5'h1F
`define ACS_SC_RESET 8'h1F
`define ACS_CLKCFG_RESET 8'h00
// Timing in converter clocks and bus clocks
`define ACS_SYNC_BUS 6'h03
`define ACS_START_CK 6'h02
`define ACS_SMP_SHORT 6'h04
`define ACS_SMP_LONG 6'h18
`define ACS_CNV_8 6'h0C
`define ACS_CNV_10 6'h0F
// Async clock start-up allowance
`define ACS_STARTUP_NS 5000
`define ACS_CLK_PERIOD_NS 10
`define ACS_STARTUP_CYC ((`ACS_STARTUP_NS) / (`ACS_CLK_PERIOD_NS))
`endif

// ==== rtl/acs_pkg.sv ====
// Types of the conversion sequencer.
// Assumes acs_map.svh supplies the numeric constants.
package acs_pkg;
    typedef struct packed {
        logic async_en;
        logic long_smp;
        logic mode10;
        logic [1:0] div;
        logic bus_sel;
    } acs_cfg_t;
    typedef struct packed {
        logic ien;
        logic cont;
        logic [4:0] chan;
    } acs_sc_t;
    typedef enum logic [2:0] {
        ACS_IDLE = 3'b000,
        ACS_SYNC = 3'b001,
        ACS_WAKE = 3'b010,
        ACS_START = 3'b011,
        ACS_SAMPLE = 3'b100,
        ACS_CONVERT = 3'b101,
        ACS_XFER = 3'b110
    } acs_state_t;
endpackage

// ==== bench/test_acs_sequencer.sv ====
// Self-checking bench of the conversion sequencer, run through its register port.
// Assumes acs_sequencer and acs_pkg; the bench drives every pin itself.
`timescale 1ns/100ps

module test_acs_sequencer
    import acs_pkg::*;
;
    logic clk, rst_n, reg_wr, reg_rd, stop_req, alt_clk_pin, async_osc_pin;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    logic [10:0] approx_in;
    logic [4:0] channel_sel;
    logic sample_en, analog_power_en, irq_req, irq_q, lg, md;
    logic [9:0] e;
    logic [10:0] ap [4] = '{11'h003, 11'h7FF, 11'h2AB, 11'h7FE};
    // Codes expected for ap, rounded to nearest and saturated
    logic [9:0] ex [4] = '{10'h000, 10'h0FF, 10'h156, 10'h3FF};
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    int t_prev = 0;
    int t_last = 0;
    int run = 0;
    int smp_len = 0;
    int n, first;

    acs_sequencer i_dut (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .stop_req(stop_req),
        .alt_clk_pin(alt_clk_pin), .async_osc_pin(async_osc_pin),
        .approx_in(approx_in), .channel_sel(channel_sel),
        .sample_en(sample_en), .analog_power_en(analog_power_en),
        .irq_req(irq_req)
    );

    // ****************************************
    // Clocks and monitors
    // ****************************************
    // Bus clock 10 ns, alternate clock 40 ns, async oscillator 60 ns
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        alt_clk_pin = 1'b0;
        forever #20 alt_clk_pin = ~alt_clk_pin;
    end
    initial begin
        async_osc_pin = 1'b0;
        forever #30 async_osc_pin = ~async_osc_pin;
    end

    // Cycle count, interrupt rise times and sample window length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        irq_q <= irq_req;
        if (irq_req === 1'b1 && irq_q !== 1'b1) begin
            t_prev <= t_last;
            t_last <= cyc;
        end
        if (sample_en === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            smp_len <= run;
            run <= 0;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    // Count and report one comparison
    task automatic chk(input string nm, input logic [15:0] s, e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic chkrd(input logic [2:0] a, input logic [7:0] x,
                         input string nm);
        rd(a, rv);
        chk(nm, 16'(rv), 16'(x));
    endtask

    // Bounded wait for the interrupt request
    task automatic wirq(input int mx);
        int i;
        i = 0;
        while (irq_req !== 1'b1 && i < mx) begin
            @(posedge clk);
            i++;
        end
        #1;
    endtask

    // Configure, start, and time until the interrupt
    task automatic conv(input logic [7:0] cfg, sc, input logic [10:0] a,
                        input int mx);
        int t0;
        approx_in <= a;
        wr(3'h3, cfg);
        wr(3'h0, sc);
        t0 = cyc;
        wirq(mx);
        n = cyc - t0;
    endtask

    task automatic finish_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        finish_test();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        rst_n = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        stop_req = 1'b0;
        approx_in = 11'h000;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chkrd(3'h0, 8'h1F, "sc");
        chkrd(3'h1, 8'h00, "res_hi");
        chkrd(3'h2, 8'h00, "res_lo");
        chkrd(3'h3, 8'h00, "clkcfg");
        chkrd(3'h5, 8'h00, "unmapped");
        chk("power", 16'(analog_power_en), 16'h0);
        for (int m = 0; m < 4; m++) begin
            lg = m[0];
            md = m[1];
            first = (md ? 21 : 18) + (lg ? 20 : 0);
            e = ex[m];
            conv({3'b000, lg, md, 3'b001}, 8'h65, ap[m], 200);
            chk("first", 16'(n >= first && n <= first + 7), 16'h1);
            chk("irq", 16'(irq_req), 16'h1);
            chk("smp", 16'(smp_len), lg ? 16'h18 : 16'h4);
            chkrd(3'h0, 8'hE5, "flag");
            chkrd(3'h1, md ? {6'h00, e[9:8]} : 8'h00, "hi");
            chkrd(3'h2, e[7:0], "lo");
            chk("irq_clr", 16'(irq_req), 16'h0);
            wirq(100);
            n = t_last - t_prev;
            chk("later", 16'(n >= first - 2 && n <= first), 16'h1);
            wr(3'h0, 8'h1F);
            chk("idle", 16'(analog_power_en), 16'h0);
        end
        approx_in <= 11'h010;
        wr(3'h3, 8'h01);
        wr(3'h0, 8'h05);
        repeat (40) @(posedge clk);
        chk("irq_off", 16'(irq_req), 16'h0);
        chkrd(3'h0, 8'h85, "flag");
        chkrd(3'h2, 8'h02, "lo");
        wr(3'h0, 8'h1F);
        chkrd(3'h0, 8'h1F, "flag_clr");
        conv(8'h09, 8'h45, 11'h100, 100);
        chkrd(3'h1, 8'h00, "hi");
        chkrd(3'h2, 8'h80, "lo");
        approx_in <= 11'h402;
        wr(3'h0, 8'h45);
        rd(3'h1, rv);
        repeat (35) @(posedge clk);
        chkrd(3'h0, 8'h45, "blocked");
        chk("restart", 16'(analog_power_en), 16'h1);
        chkrd(3'h2, 8'h80, "old_lo");
        wirq(60);
        chkrd(3'h1, 8'h02, "new_hi");
        chkrd(3'h2, 8'h01, "new_lo");
        approx_in <= 11'h000;
        wr(3'h0, 8'h45);
        repeat (10) @(posedge clk);
        wr(3'h3, 8'h09);
        chk("abort", 16'(analog_power_en), 16'h0);
        repeat (60) @(posedge clk);
        chkrd(3'h0, 8'h45, "no_flag");
        chkrd(3'h1, 8'h02, "keep_hi");
        chkrd(3'h2, 8'h01, "keep_lo");
        wr(3'h0, 8'h45);
        repeat (10) @(posedge clk);
        wr(3'h0, 8'h5F);
        chk("off", 16'(analog_power_en), 16'h0);
        chk("chan", 16'(channel_sel), 16'h1F);
        wr(3'h0, 8'h45);
        repeat (10) @(posedge clk);
        approx_in <= 11'h0FF;
        wr(3'h0, 8'h47);
        chk("chan", 16'(channel_sel), 16'h07);
        wirq(60);
        chkrd(3'h2, 8'h80, "restart_lo");
        wr(3'h0, 8'h45);
        repeat (10) @(posedge clk);
        stop_req <= 1'b1;
        @(posedge clk);
        #1;
        chk("stop", 16'(analog_power_en), 16'h0);
        stop_req <= 1'b0;
        repeat (60) @(posedge clk);
        chkrd(3'h0, 8'h45, "no_flag");
        wr(3'h3, 8'h29);
        wr(3'h0, 8'h45);
        repeat (10) @(posedge clk);
        stop_req <= 1'b1;
        wirq(1500);
        chk("async", 16'(irq_req), 16'h1);
        stop_req <= 1'b0;
        rd(3'h2, rv);
        conv(8'h07, 8'h45, 11'h008, 300);
        chk("div8", 16'(n >= 144 && n <= 164), 16'h1);
        chkrd(3'h2, 8'h01, "lo");
        conv(8'h03, 8'h45, 11'h008, 100);
        chk("div2", 16'(n >= 36 && n <= 46), 16'h1);
        conv(8'h05, 8'h45, 11'h008, 150);
        chk("div4", 16'(n >= 72 && n <= 82), 16'h1);
        conv(8'h00, 8'h45, 11'h008, 200);
        chk("alt", 16'(n >= 72 && n <= 96), 16'h1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chkrd(3'h2, 8'h00, "rst_lo");
        finish_test();
    end
endmodule // test_acs_sequencer
